// ==== bench/gpir_pins.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// pin partner: pads, pulls and outside drivers
// ---------------------------------------------
module gpir_pins #(
  parameter N = 15,
  parameter [N-1:0] PULL_UP = 15'h0e00
) (
  input wire mclk,
  input wire [N-1:0] pin_out,
  input wire [N-1:0] pin_oe_n,
  input wire [N-1:0] pull_en,
  input wire [N-1:0] ext_en,
  input wire [N-1:0] ext_val,
  output logic [N-1:0] pin_in
);
  logic [N-1:0] wobble = '0;
  // a floating pad never holds its last level
  always @(posedge mclk) wobble <= ~wobble;
  // device drive wins, then outside driver, then pull
  always_comb begin
    for (int k = 0; k < N; k++) begin
      if (!pin_oe_n[k]) pin_in[k] = pin_out[k];
      else if (ext_en[k]) pin_in[k] = ext_val[k];
      else if (pull_en[k]) pin_in[k] = PULL_UP[k];
      else pin_in[k] = wobble[k];
    end
  end
endmodule // gpir_pins

// ==== bench/gpir_port_chk.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// port checker
// ---------------------------------------------
module gpir_port_chk #(
  parameter N = 15
) (
  input wire mclk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  input wire [N-1:0] pin_out,
  input wire [N-1:0] pin_oe_n,
  input wire [N-1:0] pull_en,
  input wire [N-1:0] drive_high,
  input wire [N-1:0] func_gpio,
  input wire [N-1:0] func_first_serial,
  input wire [N-1:0] func_second_serial,
  input wire [N-1:0] func_third_serial,
  input wire irq_any
);
  wire [N-1:0] wlow = wdata[N-1:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(rd_stb) |-> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
  property p_wo_zero;
    rd_stb && addr inside {8'h20, 8'h28, 8'h3c, 8'h40} |=> rdata == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("alias read nonzero");
  property p_pull;
    wr_stb && addr == 8'h08 |-> ##2 pull_en == $past(wlow, 2);
  endproperty
  a_pull: assert property (p_pull) else $error("pull copy wrong");
  property p_drive;
    wr_stb && addr == 8'h0c |-> ##2 drive_high == $past(wlow, 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive copy wrong");
  property p_set;
    wr_stb && addr == 8'h3c |-> ##2 pin_out == ($past(pin_out) | $past(wlow, 2));
  endproperty
  a_set: assert property (p_set) else $error("set alias wrong");
  property p_clr;
    wr_stb && addr == 8'h40 |-> ##2 pin_out == ($past(pin_out) & ~$past(wlow, 2));
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias wrong");
  property p_oe;
    (~pin_oe_n & ~func_gpio) == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("drive outside gpio");
  property p_func;
    (func_gpio & (func_first_serial | func_second_serial | func_third_serial))
      == '0 && (func_first_serial & (func_second_serial | func_third_serial))
      == '0 && (func_second_serial & func_third_serial) == '0;
  endproperty
  a_func: assert property (p_func) else $error("two functions");
  c_set: cover property (wr_stb && addr == 8'h3c);
  c_irq: cover property ($rose(irq_any));
  c_mis: cover property (rd_stb && addr == 8'h24 ##1 rdata != 32'h0);
endmodule // gpir_port_chk

bind gpir_port gpir_port_chk #(.N(N)) u_chk (.mclk(mclk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
  .drive_high(drive_high), .func_gpio(func_gpio),
  .func_first_serial(func_first_serial),
  .func_second_serial(func_second_serial),
  .func_third_serial(func_third_serial), .irq_any(irq_any));

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ---------------------------------------------
// testbench
// ---------------------------------------------
module tb_top;
  logic mclk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, rd_pend = 0;
  logic [7:0] addr = 0, t;
  logic [31:0] wdata = 0, seed = 32'hfe42fb5b, rdata, exp_q[$];
  logic [31:0] exp_r, d;
  logic [14:0] ext_en = 0, ext_val = 0, v, pin_in, pin_out, pin_oe_n;
  logic [14:0] pull_en, drive_high, f_g, f_1, f_2, f_3;
  logic t1a, t1b, t2a, t2b, irq_any;
  int fails = 0, num_checks = 0;
  logic [7:0] offs [15] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c, 8'h40, 8'h44, 8'h20};
  logic [7:0] rwo [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h44, 8'h20};
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
  // sense, both, polarity, mask, start level, three expected flags
  logic [7:0] irq_tab [6] = '{8'h39, 8'h11, 8'h55, 8'hb7, 8'h9f, 8'h28};

  always #50 mclk = ~mclk;

  gpir_port #(.N(15)) DUT (.mclk(mclk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_en(pull_en), .drive_high(drive_high), .func_first_serial(f_1),
    .func_second_serial(f_2), .func_third_serial(f_3), .func_gpio(f_g),
    .timer1_input_a(t1a), .timer1_input_b(t1b), .timer2_input_a(t2a),
    .timer2_input_b(t2b), .irq_any(irq_any));

  gpir_pins #(.N(15)) u_pins (.mclk(mclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_en(pull_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1;
    @(posedge mclk);
    wr_stb <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1;
    @(posedge mclk);
    rd_stb <= 0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pins(input logic [14:0] p);
    @(posedge mclk);
    ext_en <= 15'h7fff;
    ext_val <= p;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // read answers land one cycle late; match them to the oldest note
  always @(posedge mclk) rd_pend <= rd_stb;
  always @(negedge mclk) if (rd_pend) begin
    exp_r = exp_q.pop_front();
    `CHK(rdata, exp_r)
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    results();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1;
    tick(3);
    `CHK({pull_en, pin_oe_n, f_1}, {15'h7fff, 15'h7fff, 15'h0600})
    foreach (offs[i]) rd(offs[i], offs[i] == 8'h08 ? 32'h3fffff :
      offs[i] == 8'h30 ? 32'h110 : 32'h0);
    foreach (rwo[i]) begin
      seed = lfsr(seed);
      // reserved bits written at their reset value
      d = rwo[i] == 8'h44 ? seed : {17'h0, seed[14:0]} |
        (rwo[i] == 8'h08 ? 32'h003f8000 : 32'h0);
      wr(rwo[i], d);
      rd(rwo[i], rwo[i] == 8'h20 ? 32'h0 : d);
      tick(1);
      if (rwo[i] == 8'h0c) `CHK(drive_high, seed[14:0])
      if (rwo[i] == 8'h08) `CHK(pull_en, seed[14:0])
      wr(rwo[i], rwo[i] == 8'h08 ? 32'h003f8000 : 32'h0);
    end
    wr(8'h30, 32'h0);
    wr(8'h04, 32'h7fff);
    seed = lfsr(seed);
    v = (seed[14:0] | 15'h0005) & ~15'h0300;
    wr(8'h00, seed);
    wr(8'h3c, 32'h0005);
    wr(8'h40, 32'h0300);
    tick(4);
    `CHK({pin_oe_n, pin_out}, {15'h0, v})
    rd(8'h00, {17'h0, v});
    foreach (codes[i]) begin
      wr(8'h2c, 32'h11111111 * codes[i]);
      wr(8'h30, 32'h01111111 * codes[i]);
      rd(8'h2c, 32'h11111111 * codes[i]);
      tick(1);
      `CHK({f_g, f_1, f_2, f_3, pin_oe_n}, {{15{codes[i] == 0}},
        {15{codes[i] == 1}}, {15{codes[i] == 4}}, {15{codes[i] == 5}},
        {15{codes[i] != 0}}})
    end
    wr(8'h2c, 32'h0);
    wr(8'h30, 32'h0);
    wr(8'h04, 32'h0);
    pins(~v);
    tick(4);
    rd(8'h00, {17'h0, ~v});
    foreach (irq_tab[i]) begin
      t = irq_tab[i];
      wr(8'h10, {31'h0, t[7]});
      wr(8'h14, {31'h0, t[6]});
      wr(8'h18, {31'h0, t[5]});
      wr(8'h1c, {31'h0, t[4]});
      pins({14'h0, t[3]});
      tick(5);
      wr(8'h28, 32'h7fff);
      pins({14'h0, ~t[3]});
      tick(5);
      `CHK(irq_any, t[2])
      rd(8'h24, {31'h0, t[2]});
      wr(8'h28, 32'h1);
      rd(8'h24, {31'h0, t[1]});
      pins({14'h0, t[3]});
      tick(5);
      rd(8'h24, {31'h0, t[0]});
    end
    wr(8'h44, 32'h070f0e02);
    repeat (2) begin
      seed = lfsr(seed);
      pins(seed[14:0]);
      tick(5);
      `CHK({t1a, t1b, t2a, t2b}, {seed[2], seed[14], 1'b0, seed[7]})
    end
    tick(2);
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule // tb_top

// ==== pkg/gpir_regs.vh ====
`ifndef GPIR_REGS_VH
`define GPIR_REGS_VH
// register byte offsets
`define GPIR_OFF_PIN_DATA 8'h00
`define GPIR_OFF_DIRECTION 8'h04
`define GPIR_OFF_PULL_EN 8'h08
`define GPIR_OFF_DRIVE 8'h0c
`define GPIR_OFF_SENSE 8'h10
`define GPIR_OFF_BOTH_EDGES 8'h14
`define GPIR_OFF_POLARITY 8'h18
`define GPIR_OFF_MASK 8'h1c
`define GPIR_OFF_MASKED_FLAGS 8'h24
`define GPIR_OFF_CLEAR 8'h28
`define GPIR_OFF_FUNC_LOW 8'h2c
`define GPIR_OFF_FUNC_HIGH 8'h30
`define GPIR_OFF_SET_ALIAS 8'h3c
`define GPIR_OFF_CLR_ALIAS 8'h40
`define GPIR_OFF_TIMER_SEL 8'h44
// reset values
`define GPIR_RST_ZERO 32'h00000000
`define GPIR_RST_PULL_EN 32'h003fffff
`define GPIR_RST_FUNC_HIGH 32'h00000110
// function field layout and codes
`define GPIR_FUNC_W 4
`define GPIR_FUNC_GPIO 3'h0
`define GPIR_FUNC_SER1 3'h1
`define GPIR_FUNC_SER2 3'h4
`define GPIR_FUNC_SER3 3'h5
// timer selector field width
`define GPIR_TSEL_W 8
`endif

// ==== src/gpir_detect.v ====
`timescale 1ns/1ps
// per-pin interrupt trigger decode, purely combinational
module gpir_detect #(
  parameter N = 15
) (
  input wire [N-1:0] cur,
  input wire [N-1:0] prev,
  input wire [N-1:0] sense,
  input wire [N-1:0] both,
  input wire [N-1:0] pol,
  output wire [N-1:0] edge_hit,
  output wire [N-1:0] level_hit
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pin
      wire rise;
      wire fall;
      assign rise = cur[i] & ~prev[i];
      assign fall = ~cur[i] & prev[i];
      assign edge_hit[i] = ~sense[i] &
        (both[i] ? (rise | fall) : (pol[i] ? rise : fall));
      assign level_hit[i] = sense[i] & (cur[i] == pol[i]);
    end
  endgenerate
endmodule // gpir_detect

// ==== src/gpir_port.v ====
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
//
// Overview of operation
// - GPIO output pins drive the last written output data bit.
// - Reading pin data returns the live pin level.
// - One direction bit per pin, 1 is output, resets to zero.
// - One pull-enable bit per pin, reset to printed pattern.
// - One drive-strength bit per pin, 1 is high drive, reset zero.
// - Sense bit selects edge (0) or level (1) interrupt detection.
// - Edge pins trigger on one edge or both edges.
// - Polarity bit picks falling/low (0) or rising/high (1).
// - Mask bit enables each pin interrupt, all reset zero.
// - Read-only masked status shows pending and enabled pins.
// - Writing one to the clear register clears that pending bit.
// - IO0-IO7 have 3-bit function fields with reserved bit above.
// - IO8-IO14 function register resets IO9, IO10 to first serial.
// - Ones written to set alias set output data bits.
// - Ones written to clear alias clear output data bits.
// - A register routes chosen pins to timer capture inputs.
// - Four 8-bit selector fields, values 0 to 14 pick pins.
//
`include "gpir_regs.vh"
module gpir_port #(
  parameter N = 15
) (
  input wire mclk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire [N-1:0] pin_in,
  output reg [N-1:0] pin_out,
  output reg [N-1:0] pin_oe_n,
  output reg [N-1:0] pull_en,
  output reg [N-1:0] drive_high,
  output reg [N-1:0] func_first_serial,
  output reg [N-1:0] func_second_serial,
  output reg [N-1:0] func_third_serial,
  output reg [N-1:0] func_gpio,
  output reg timer1_input_a,
  output reg timer1_input_b,
  output reg timer2_input_a,
  output reg timer2_input_b,
  output reg irq_any
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta;
  reg rst_n;

  // async assert, sync release through two flops
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [N-1:0] out_data;
  reg [N-1:0] direction_bits;
  reg [31:0] pull_enable_bits;
  reg [31:0] drive_strength_bits;
  reg [N-1:0] irq_sense_select;
  reg [N-1:0] irq_both_edges;
  reg [N-1:0] irq_polarity;
  reg [N-1:0] irq_mask;
  reg [N-1:0] pending;
  reg [31:0] pin_function_low;
  reg [31:0] pin_function_high;
  reg [31:0] timer_input_pin_select;
  reg [31:0] next_rdata;
  reg [N-1:0] next_out_data;

  wire [N-1:0] pin_sync;
  wire [N-1:0] pin_prev;
  wire [N-1:0] edge_hit;
  wire [N-1:0] level_hit;
  wire [N-1:0] clr_bits;
  wire [63:0] func_all;

  // fields of both function registers joined, 4 bits per pin
  assign func_all = {pin_function_high, pin_function_low};

  // returns a 3-bit function code of pin p
  function [2:0] func_of;
    input [63:0] all;
    input integer p;
    begin
      func_of = all[p*`GPIR_FUNC_W +: 3];
    end
  endfunction

  // picks one synchronised pin by an 8-bit selector; out of range reads 0
  function pick_pin;
    input [N-1:0] pins;
    input [7:0] sel;
    begin
      if (sel < N)
        pick_pin = pins[sel[3:0]];
      else
        pick_pin = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin sampling and trigger decode
  // ----------------------------------------------------------------
  // synchronise then compare to previous
  gpir_sync #(.N(N)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_sync),
    .prev_out(pin_prev)
  );

  gpir_detect #(.N(N)) u_detect (
    .cur(pin_sync),
    .prev(pin_prev),
    .sense(irq_sense_select),
    .both(irq_both_edges),
    .pol(irq_polarity),
    .edge_hit(edge_hit),
    .level_hit(level_hit)
  );

  assign clr_bits = (wr_stb && addr == `GPIR_OFF_CLEAR) ?
    wdata[N-1:0] : {N{1'b0}};

  // ----------------------------------------------------------------
  // output data with set and clear aliases
  // ----------------------------------------------------------------
  // aliases touch only the bits written as one
  always @* begin
    next_out_data = out_data;
    if (wr_stb) begin
      case (addr)
        `GPIR_OFF_PIN_DATA: next_out_data = wdata[N-1:0];
        `GPIR_OFF_SET_ALIAS: next_out_data = out_data | wdata[N-1:0];
        `GPIR_OFF_CLR_ALIAS: next_out_data = out_data & ~wdata[N-1:0];
        default: next_out_data = out_data;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // reserved bits of the 32-bit registers are stored as written; software keeps them at reset
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= {N{1'b0}};
      direction_bits <= {N{1'b0}};
      pull_enable_bits <= `GPIR_RST_PULL_EN;
      drive_strength_bits <= `GPIR_RST_ZERO;
      irq_sense_select <= {N{1'b0}};
      irq_both_edges <= {N{1'b0}};
      irq_polarity <= {N{1'b0}};
      irq_mask <= {N{1'b0}};
      pin_function_low <= `GPIR_RST_ZERO;
      pin_function_high <= `GPIR_RST_FUNC_HIGH;
      timer_input_pin_select <= `GPIR_RST_ZERO;
    end else begin
      out_data <= next_out_data;
      if (wr_stb) begin
        case (addr)
          `GPIR_OFF_DIRECTION: direction_bits <= wdata[N-1:0];
          `GPIR_OFF_PULL_EN: pull_enable_bits <= wdata;
          `GPIR_OFF_DRIVE: drive_strength_bits <= wdata;
          `GPIR_OFF_SENSE: irq_sense_select <= wdata[N-1:0];
          `GPIR_OFF_BOTH_EDGES: irq_both_edges <= wdata[N-1:0];
          `GPIR_OFF_POLARITY: irq_polarity <= wdata[N-1:0];
          `GPIR_OFF_MASK: irq_mask <= wdata[N-1:0];
          `GPIR_OFF_FUNC_LOW: pin_function_low <= wdata;
          `GPIR_OFF_FUNC_HIGH: pin_function_high <= wdata;
          `GPIR_OFF_TIMER_SEL: timer_input_pin_select <= wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pending interrupt flags
  // ----------------------------------------------------------------
  // no edges until the sampler holds real pin levels after reset
  reg [2:0] warm;

  // pulled-up pins would otherwise show a false rising edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      warm <= 3'b000;
    else
      warm <= {warm[1:0], 1'b1};
  end

  // a new trigger in the clear cycle wins over the clear
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      pending <= {N{1'b0}};
    else
      pending <= (pending & ~clr_bits) | (edge_hit & {N{warm[2]}}) |
        level_hit;
  end

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `GPIR_OFF_PIN_DATA: next_rdata[N-1:0] = pin_sync;
      `GPIR_OFF_DIRECTION: next_rdata[N-1:0] = direction_bits;
      `GPIR_OFF_PULL_EN: next_rdata = pull_enable_bits;
      `GPIR_OFF_DRIVE: next_rdata = drive_strength_bits;
      `GPIR_OFF_SENSE: next_rdata[N-1:0] = irq_sense_select;
      `GPIR_OFF_BOTH_EDGES: next_rdata[N-1:0] = irq_both_edges;
      `GPIR_OFF_POLARITY: next_rdata[N-1:0] = irq_polarity;
      `GPIR_OFF_MASK: next_rdata[N-1:0] = irq_mask;
      `GPIR_OFF_MASKED_FLAGS: next_rdata[N-1:0] = pending & irq_mask;
      `GPIR_OFF_FUNC_LOW: next_rdata = pin_function_low;
      `GPIR_OFF_FUNC_HIGH: next_rdata = pin_function_high;
      `GPIR_OFF_TIMER_SEL: next_rdata = timer_input_pin_select;
      // write-only and alias registers read zero
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data stands one cycle, zero otherwise
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (rd_stb)
      rdata <= next_rdata;
    else
      rdata <= 32'h00000000;
  end

  // ----------------------------------------------------------------
  // pad controls and function decode, all registered
  // ----------------------------------------------------------------
  integer k;
  reg [N-1:0] next_gpio;
  reg [N-1:0] next_s1;
  reg [N-1:0] next_s2;
  reg [N-1:0] next_s3;

  always @* begin
    next_gpio = {N{1'b0}};
    next_s1 = {N{1'b0}};
    next_s2 = {N{1'b0}};
    next_s3 = {N{1'b0}};
    for (k = 0; k < N; k = k + 1) begin
      next_gpio[k] = (func_of(func_all, k) == `GPIR_FUNC_GPIO);
      next_s1[k] = (func_of(func_all, k) == `GPIR_FUNC_SER1);
      next_s2[k] = (func_of(func_all, k) == `GPIR_FUNC_SER2);
      next_s3[k] = (func_of(func_all, k) == `GPIR_FUNC_SER3);
    end
  end

  // pads hold high impedance during reset; one cycle of latency
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= {N{1'b0}};
      pin_oe_n <= {N{1'b1}};
      pull_en <= {N{1'b0}};
      drive_high <= {N{1'b0}};
    end else begin
      pin_out <= out_data;
      // a pin in a serial function is never driven from here
      pin_oe_n <= ~(direction_bits & next_gpio);
      pull_en <= pull_enable_bits[N-1:0];
      drive_high <= drive_strength_bits[N-1:0];
    end
  end

  // function strobes registered so the pad mux sees no glitch
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      func_gpio <= {N{1'b0}};
      func_first_serial <= {N{1'b0}};
      func_second_serial <= {N{1'b0}};
      func_third_serial <= {N{1'b0}};
    end else begin
      func_gpio <= next_gpio;
      func_first_serial <= next_s1;
      func_second_serial <= next_s2;
      func_third_serial <= next_s3;
    end
  end

  // ----------------------------------------------------------------
  // timer capture inputs
  // ----------------------------------------------------------------
  wire [3:0] next_timer;

  // one 8-bit selector per timer input
  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : g_tsel
      // codes above the last pin read low instead of aliasing a pin
      assign next_timer[j] = pick_pin(pin_sync,
        timer_input_pin_select[j*`GPIR_TSEL_W +: `GPIR_TSEL_W]);
    end
  endgenerate

  // registered so a timer never sees a half-written selector
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_input_a <= 1'b0;
      timer1_input_b <= 1'b0;
      timer2_input_a <= 1'b0;
      timer2_input_b <= 1'b0;
    end else begin
      timer1_input_a <= next_timer[0];
      timer1_input_b <= next_timer[1];
      timer2_input_a <= next_timer[2];
      timer2_input_b <= next_timer[3];
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  // level summary of enabled pending pins, no interrupt logic here
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      irq_any <= 1'b0;
    else
      irq_any <= |(pending & irq_mask);
  end
endmodule // gpir_port

// ==== src/gpir_sync.v ====
`timescale 1ns/1ps
// two-stage synchroniser plus previous sample, one per pin
module gpir_sync #(
  parameter N = 15
) (
  input wire mclk,
  input wire rst_n,
  input wire [N-1:0] async_in,
  output reg [N-1:0] sync_out,
  output reg [N-1:0] prev_out
);
  reg [N-1:0] stage1;

  // stage1 feeds only sync_out
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {N{1'b0}};
      sync_out <= {N{1'b0}};
      prev_out <= {N{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
      prev_out <= sync_out;
    end
  end
endmodule // gpir_sync
